// File: verif/tb_timer_capture_compare_output.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/1ns
module tb_timer_capture_compare_output;
  import tccu_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pad = 8'h00;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] prd;
  logic prdy;
  logic perr;
  logic er;
  logic [6:0] areq = 7'h00;
  logic [6:0] breq = 7'h10;
  logic [6:0] ain;
  logic [6:0] bin;
  logic [6:0] uout;
  logic irq0;
  logic irqs;
  logic [15:0] r;
  logic [15:0] k;
  int fails = 0;
  int total_checks = 0;
  int p;
  int c;
  int h;
  int e;
  int mx;
  always #5 clk = ~clk;
  tccu_pins pins (.clock_in(clk), .a_req_in(areq), .b_req_in(breq), .a_out(ain), .b_out(bin));
  tccu_timer dut (.clock_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pad), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .capture_input_a_in(ain), .capture_input_b_in(bin),
    .unit_output_out(uout), .irq_channel0_out(irq0), .irq_shared_out(irqs));
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    total_checks++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] i, input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pad <= {i[5:0], 2'b00};
    pwd <= {16'h0000, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    r = prd[15:0];
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, input logic [15:0] x);
    bus(1'b0, i, 16'h0000);
    chk(r, x);
  endtask
  function automatic logic [7:0] cc(input int n);
    return IDX_CCTL0 + 8'(2 * n);
  endfunction
  function automatic logic [7:0] cr(input int n);
    return IDX_CCR0 + 8'(2 * n);
  endfunction
  // all three read phases, so a one-cycle peak is not missed
  task automatic sweep(input int n);
    mx = 0;
    repeat (3) begin
      repeat (n) begin
        bus(1'b0, IDX_CNT, 16'h0000);
        if (r > mx) mx = r;
      end
      @(posedge clk);
    end
  endtask
  initial begin
    void'($urandom(32'h93b0));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) rd(8'(2 * i), 16'h0000);
    rd(IDX_IV, 16'h0000);
    bus(1'b0, 8'h01, 16'h0000);
    chk({15'h0000, er}, 16'h0001);
    p = 20 + $urandom % 20;
    c = 1 + $urandom % (p - 1);
    k = 16'($urandom);
    bus(1'b1, cr(6), k);
    rd(cr(6), k);
    bus(1'b1, cr(0), 16'(p));
    bus(1'b1, cr(1), 16'(c));
    bus(1'b1, cc(1), 16'h0004);
    @(negedge clk);
    chk({15'h0000, uout[1]}, 16'h0001);
    bus(1'b1, IDX_CTL, {10'h000, CNT_UP, 4'h0});
    for (int m = 1; m < 8; m++) begin
      bus(1'b1, cc(1), 16'h00E0);
      bus(1'b1, cc(1), 16'(m << 5));
      repeat (2 * p + 2) @(negedge clk);
      h = 0;
      repeat (2 * p + 2) begin
        @(negedge clk);
        h += uout[1];
      end
      case (m)
        1: e = 2 * p + 2;
        2, 3: e = 2 * (p - c);
        4: e = p + 1;
        5: e = 0;
        default: e = 2 * (c + 1);
      endcase
      chk(16'(h), 16'(e));
    end
    rd(cc(1), 16'h00E1);
    bus(1'b1, IDX_CTL, 16'h0000);
    bus(1'b1, cc(1), 16'h0000);
    bus(1'b1, IDX_CNT, 16'(c));
    rd(cc(1), 16'h0000);
    bus(1'b1, IDX_CTL, {10'h000, CNT_UPDN, 4'h0});
    sweep(2 * p + 2);
    chk(16'(mx), 16'(p));
    bus(1'b1, cr(0), 16'(p + 7));
    sweep(2 * p + 16);
    chk(16'(mx), 16'(p + 7));
    bus(1'b1, IDX_CTL, 16'h0000);
    bus(1'b1, IDX_CNT, k);
    bus(1'b1, cc(2), 16'hE100);
    bus(1'b1, cc(2), 16'hF100);
    repeat (3) @(posedge clk);
    rd(cr(2), k);
    bus(1'b1, cc(2), 16'hE100);
    bus(1'b1, cc(2), 16'hF100);
    repeat (3) @(posedge clk);
    rd(cc(2), 16'hF10B);
    bus(1'b1, cc(2), 16'hF100);
    rd(cc(2), 16'hF108);
    bus(1'b1, cc(3), 16'h0900);
    bus(1'b1, cc(3), 16'h4900);
    areq[3] <= 1'b1;
    repeat (4) @(posedge clk);
    rd(cc(3), 16'h4909);
    bus(1'b1, cc(3), 16'h4900);
    areq[3] <= 1'b0;
    repeat (4) @(posedge clk);
    rd(cc(3), 16'h4900);
    bus(1'b1, cc(4), 16'h9100);
    breq[4] <= 1'b0;
    repeat (4) @(posedge clk);
    rd(cc(4), 16'h9101);
    bus(1'b1, IDX_CTL, 16'h8000);
    bus(1'b1, cc(0), 16'h0011);
    @(negedge clk);
    chk({14'h0000, irq0, irqs}, 16'h0002);
    bus(1'b1, cc(0), 16'h0001);
    bus(1'b1, cc(5), 16'h0011);
    @(negedge clk);
    chk({14'h0000, irq0, irqs}, 16'h0001);
    rd(IDX_IV, 16'h000A);
    @(negedge clk);
    chk({14'h0000, irq0, irqs}, 16'h0000);
    end_of_test();
  end
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
endmodule

// File: verif/tccu_pins.sv
// capture pin model for both sources
`timescale 1ns/1ns
module tccu_pins (
  // clock
  input wire logic clock_in,
  // levels asked by the bench
  input wire logic [tccu_pkg::NCH-1:0] a_req_in,
  input wire logic [tccu_pkg::NCH-1:0] b_req_in,
  // pins
  output logic [tccu_pkg::NCH-1:0] a_out,
  output logic [tccu_pkg::NCH-1:0] b_out
);
  import tccu_pkg::*;
  // pins move after an edge, unrelated to the bus
  always @(posedge clock_in) begin
    a_out <= a_req_in;
    b_out <= b_req_in;
  end
endmodule

// File: verif/tccu_timer_properties.sv
// port assertions for the timer
`timescale 1ns/1ns
module tccu_props (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // pins
  input wire logic [tccu_pkg::NCH-1:0] capture_input_a_in,
  input wire logic [tccu_pkg::NCH-1:0] capture_input_b_in,
  input wire logic [tccu_pkg::NCH-1:0] unit_output_out,
  input wire logic irq_channel0_out,
  input wire logic irq_shared_out
);
  import tccu_pkg::*;
  localparam logic [7:0] CC1 = IDX_CCTL0 + 8'h02;
  logic wr;
  logic clr_wr;
  logic gie_reg;
  logic ie0_reg;
  logic ov1_reg;
  logic [2:0] om1_reg;
  assign wr = psel_in && penable_in && pwrite_in;
  assign clr_wr = wr && paddr_in[7:2] == IDX_CTL[5:0] && pwdata_in[CTL_CLR_BIT];
  // shadows follow software writes only
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      gie_reg <= 1'b0;
      ie0_reg <= 1'b0;
      om1_reg <= OM_OUT;
      ov1_reg <= 1'b0;
    end else if (wr) begin
      if (paddr_in[7:2] == IDX_CTL[5:0]) gie_reg <= pwdata_in[CTL_GIE_BIT];
      if (paddr_in[7:2] == IDX_CCTL0[5:0]) ie0_reg <= pwdata_in[CC_IE_BIT];
      if (paddr_in[7:2] == CC1[5:0]) begin
        om1_reg <= pwdata_in[CC_OM_LSB+:3];
        ov1_reg <= pwdata_in[CC_OUTVAL_BIT];
      end
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_ready_high: assert property (pready_out) else $error("not ready");
  a_err_access: assert property (pslverr_out |-> psel_in && penable_in) else $error("bad err");
  a_err_odd: assert property (psel_in && penable_in && paddr_in[2] |-> pslverr_out)
    else $error("odd index no err");
  a_rdata_upper: assert property (prdata_out[31:16] == 16'h0000) else $error("upper data");
  a_irq0_gate: assert property (irq_channel0_out |-> gie_reg && ie0_reg)
    else $error("irq0 ungated");
  a_irqs_gate: assert property (irq_shared_out |-> gie_reg)
    else $error("shared irq ungated");
  a_mode0_out: assert property (om1_reg == OM_OUT |-> unit_output_out[1] == ov1_reg)
    else $error("mode0 output");
  a_mode1_hold: assert property (om1_reg == OM_SET && $past(om1_reg) == OM_SET
    && !$past(clr_wr) |-> !$fell(unit_output_out[1])) else $error("mode1 fell");
  a_mode5_hold: assert property (om1_reg == OM_RST && $past(om1_reg) == OM_RST
    |-> !$rose(unit_output_out[1])) else $error("mode5 rose");
endmodule
bind tccu_timer tccu_props props_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .capture_input_a_in(capture_input_a_in), .capture_input_b_in(capture_input_b_in),
  .unit_output_out(unit_output_out), .irq_channel0_out(irq_channel0_out),
  .irq_shared_out(irq_shared_out));

// File: verilog/tccu_pkg.sv
// constants, field layout and state type of the timer capture/compare unit
package tccu_pkg;
  localparam int NCH = 7;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTL = 8'h00;
  localparam logic [7:0] IDX_CCTL0 = 8'h02;
  localparam logic [7:0] IDX_CNT = 8'h10;
  localparam logic [7:0] IDX_CCR0 = 8'h12;
  localparam logic [7:0] IDX_IV = 8'h2E;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  // control register fields
  localparam int CTL_OVF_BIT = 0;
  localparam int CTL_OVIE_BIT = 1;
  localparam int CTL_CLR_BIT = 2;
  localparam int CTL_MODE_LSB = 4;
  localparam int CTL_GIE_BIT = 15;
  // channel control fields
  localparam int CC_FLAG_BIT = 0;
  localparam int CC_OVR_BIT = 1;
  localparam int CC_OUTVAL_BIT = 2;
  localparam int CC_LEVEL_BIT = 3;
  localparam int CC_IE_BIT = 4;
  localparam int CC_OM_LSB = 5;
  localparam int CC_CAPSEL_BIT = 8;
  localparam int CC_LATCH_BIT = 10;
  localparam int CC_SYNC_BIT = 11;
  localparam int CC_SRC_LSB = 12;
  localparam int CC_EDGE_LSB = 14;
  // count modes
  localparam logic [1:0] CNT_STOP = 2'h0;
  localparam logic [1:0] CNT_UP = 2'h1;
  localparam logic [1:0] CNT_CONT = 2'h2;
  localparam logic [1:0] CNT_UPDN = 2'h3;
  // capture edge modes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // capture sources
  localparam logic [1:0] SRC_A = 2'h0;
  localparam logic [1:0] SRC_B = 2'h1;
  localparam logic [1:0] SRC_GND = 2'h2;
  localparam logic [1:0] SRC_VCC = 2'h3;
  // output modes
  localparam logic [2:0] OM_OUT = 3'h0;
  localparam logic [2:0] OM_SET = 3'h1;
  localparam logic [2:0] OM_TGL_RST = 3'h2;
  localparam logic [2:0] OM_SET_RST = 3'h3;
  localparam logic [2:0] OM_TGL = 3'h4;
  localparam logic [2:0] OM_RST = 3'h5;
  localparam logic [2:0] OM_TGL_SET = 3'h6;
  localparam logic [2:0] OM_RST_SET = 3'h7;
  // vector code of the overflow flag
  localparam logic [15:0] IV_OVF = 16'h000E;

  typedef struct packed {
    logic [1:0] cnt_mode;
    logic ovie;
    logic ovf;
    logic global_irq_enable;
    logic [15:0] cnt;
    logic down;
    logic [NCH-1:0][1:0] edge_sel;
    logic [NCH-1:0][1:0] src;
    logic [NCH-1:0][2:0] om;
    logic [NCH-1:0][15:0] ccr;
    logic [NCH-1:0] sync;
    logic [NCH-1:0] latched;
    logic [NCH-1:0] capsel;
    logic [NCH-1:0] ie;
    logic [NCH-1:0] outval;
    logic [NCH-1:0] ovr;
    logic [NCH-1:0] flag;
    logic [NCH-1:0] out;
    logic [NCH-1:0] unread;
    logic [NCH-1:0] in_d;
    logic [NCH-1:0] in_dd;
    logic [31:0] rdata;
  } tccu_state_t;
endpackage

// File: verilog/tccu_timer.sv
// timer counter with capture/compare channels, output units and apb registers
`timescale 1ns/1ns
module tccu_timer (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // capture inputs
  input wire logic [tccu_pkg::NCH-1:0] capture_input_a_in,
  input wire logic [tccu_pkg::NCH-1:0] capture_input_b_in,
  // output units and interrupt requests
  output logic [tccu_pkg::NCH-1:0] unit_output_out,
  output logic irq_channel0_out,
  output logic irq_shared_out
);
  import tccu_pkg::*;

  tccu_state_t s_reg;
  tccu_state_t s_next;
  logic [7:0] idx;
  logic setup;
  logic acc;
  logic wr;
  logic mapped;
  logic in_cctl;
  logic in_ccr;
  logic [2:0] ch;
  logic [NCH-1:0] lvl;
  logic [NCH-1:0] capt_edge;
  logic [NCH-1:0] eqn;
  logic eq0;
  logic run;
  logic clr;
  logic cnt_wr;
  logic wrap;
  logic nd;
  logic [15:0] nxt;
  logic [15:0] iv;
  logic [15:0] cctl_rd;
  logic [2:0] iv_ch;

  // apb decode
  assign idx = {2'b00, paddr_in[7:2]};
  assign setup = psel_in & ~penable_in;
  assign acc = psel_in & penable_in;
  assign in_cctl = (idx >= IDX_CCTL0) && (idx < IDX_CCTL0 + 8'(2 * NCH)) && !idx[0];
  assign in_ccr = (idx >= IDX_CCR0) && (idx < IDX_CCR0 + 8'(2 * NCH)) && !idx[0];
  assign ch = in_cctl ? 3'((idx - IDX_CCTL0) >> 1) : 3'((idx - IDX_CCR0) >> 1);
  assign mapped = in_cctl || in_ccr || idx == IDX_CTL || idx == IDX_CNT || idx == IDX_IV;
  assign wr = acc & pwrite_in & mapped;
  // no wait states: read data is latched in the setup cycle
  assign pready_out = 1'b1;
  assign pslverr_out = acc & ~mapped;
  assign prdata_out = s_reg.rdata;
  assign clr = wr && idx == IDX_CTL && pwdata_in[CTL_CLR_BIT];
  assign cnt_wr = wr && idx == IDX_CNT;

  // selected capture level per channel
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      case (s_reg.src[i])
        SRC_A: begin
          lvl[i] = capture_input_a_in[i];
        end
        SRC_B: begin
          lvl[i] = capture_input_b_in[i];
        end
        SRC_GND: begin
          lvl[i] = 1'b0;
        end
        default: begin
          lvl[i] = 1'b1;
        end
      endcase
    end
  end

  // edge detection; synced path looks one sample later
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      logic a;
      logic b;
      a = s_reg.sync[i] ? s_reg.in_d[i] : lvl[i];
      b = s_reg.sync[i] ? s_reg.in_dd[i] : s_reg.in_d[i];
      case (s_reg.edge_sel[i])
        EDGE_RISE: begin
          capt_edge[i] = a & ~b;
        end
        EDGE_FALL: begin
          capt_edge[i] = ~a & b;
        end
        EDGE_BOTH: begin
          capt_edge[i] = a ^ b;
        end
        default: capt_edge[i] = 1'b0;
      endcase
      capt_edge[i] = capt_edge[i] & s_reg.capsel[i];
    end
  end

  // counter next value
  always_comb begin
    nxt = s_reg.cnt;
    nd = s_reg.down;
    wrap = 1'b0;
    // a direct write or clear never counts
    run = s_reg.cnt_mode != CNT_STOP && !cnt_wr && !clr &&
      !((s_reg.cnt_mode == CNT_UP || s_reg.cnt_mode == CNT_UPDN) &&
      s_reg.ccr[0] == RESET_VALUE);
    case (s_reg.cnt_mode)
      CNT_UP: begin
        if (s_reg.cnt >= s_reg.ccr[0]) begin
          nxt = RESET_VALUE;
          wrap = 1'b1;
        end else begin
          nxt = s_reg.cnt + 16'h0001;
        end
      end
      CNT_CONT: begin
        nxt = s_reg.cnt + 16'h0001;
        wrap = s_reg.cnt == 16'hFFFF;
      end
      CNT_UPDN: begin
        if (s_reg.down) begin
          // period is only looked at while ascending
          if (s_reg.cnt == RESET_VALUE) begin
            nd = 1'b0;
            nxt = 16'h0001;
          end else begin
            nxt = s_reg.cnt - 16'h0001;
            wrap = s_reg.cnt == 16'h0001;
            nd = s_reg.cnt != 16'h0001;
          end
        end else if (s_reg.cnt >= s_reg.ccr[0]) begin
          // reached or passed a lowered period: turn
          nd = 1'b1;
          nxt = s_reg.cnt - 16'h0001;
        end else begin
          nxt = s_reg.cnt + 16'h0001;
        end
      end
      default: nxt = s_reg.cnt;
    endcase
    eq0 = run && nxt == s_reg.ccr[0];
    for (int i = 0; i < NCH; i++) begin
      eqn[i] = run && !s_reg.capsel[i] && nxt == s_reg.ccr[i];
    end
  end

  // vector code: lowest enabled shared source wins
  always_comb begin
    iv = RESET_VALUE;
    iv_ch = 3'h0;
    if (s_reg.ovf && s_reg.ovie) begin
      iv = IV_OVF;
    end
    for (int i = NCH - 1; i >= 1; i--) begin
      if (s_reg.flag[i] && s_reg.ie[i]) begin
        iv = 16'(2 * i);
        iv_ch = 3'(i);
      end
    end
  end

  // channel control readback
  always_comb begin
    cctl_rd = RESET_VALUE;
    cctl_rd[CC_EDGE_LSB +: 2] = s_reg.edge_sel[ch];
    cctl_rd[CC_SRC_LSB +: 2] = s_reg.src[ch];
    cctl_rd[CC_SYNC_BIT] = s_reg.sync[ch];
    cctl_rd[CC_LATCH_BIT] = s_reg.latched[ch];
    cctl_rd[CC_CAPSEL_BIT] = s_reg.capsel[ch];
    cctl_rd[CC_OM_LSB +: 3] = s_reg.om[ch];
    cctl_rd[CC_IE_BIT] = s_reg.ie[ch];
    cctl_rd[CC_LEVEL_BIT] = lvl[ch];
    cctl_rd[CC_OUTVAL_BIT] = s_reg.outval[ch];
    cctl_rd[CC_OVR_BIT] = s_reg.ovr[ch];
    cctl_rd[CC_FLAG_BIT] = s_reg.flag[ch];
  end

  always_comb begin
    s_next = s_reg;
    s_next.in_d = lvl;
    s_next.in_dd = s_reg.in_d;
    // read data latched in the setup cycle
    if (setup) begin
      s_next.rdata = 32'h0000_0000;
      if (idx == IDX_CTL) begin
        s_next.rdata[CTL_GIE_BIT] = s_reg.global_irq_enable;
        s_next.rdata[CTL_MODE_LSB +: 2] = s_reg.cnt_mode;
        s_next.rdata[CTL_OVIE_BIT] = s_reg.ovie;
        s_next.rdata[CTL_OVF_BIT] = s_reg.ovf;
      end else if (idx == IDX_CNT) begin
        s_next.rdata[15:0] = s_reg.cnt;
      end else if (idx == IDX_IV) begin
        s_next.rdata[15:0] = iv;
      end else if (in_cctl) begin
        s_next.rdata[15:0] = cctl_rd;
      end else if (in_ccr) begin
        s_next.rdata[15:0] = s_reg.ccr[ch];
      end
    end
    // read of a channel value marks it consumed
    if (acc && !pwrite_in && in_ccr) begin
      s_next.unread[ch] = 1'b0;
    end
    // any access of the vector clears the flag it reported
    if (acc && idx == IDX_IV) begin
      if (s_reg.rdata[15:0] == IV_OVF) begin
        s_next.ovf = 1'b0;
      end else if (s_reg.rdata[15:0] != RESET_VALUE) begin
        s_next.flag[3'(s_reg.rdata[3:1])] = 1'b0;
      end
    end
    // software writes
    if (wr && idx == IDX_CTL) begin
      s_next.global_irq_enable = pwdata_in[CTL_GIE_BIT];
      s_next.cnt_mode = pwdata_in[CTL_MODE_LSB +: 2];
      s_next.ovie = pwdata_in[CTL_OVIE_BIT];
      s_next.ovf = pwdata_in[CTL_OVF_BIT];
    end
    if (wr && in_cctl) begin
      s_next.edge_sel[ch] = pwdata_in[CC_EDGE_LSB +: 2];
      s_next.src[ch] = pwdata_in[CC_SRC_LSB +: 2];
      s_next.sync[ch] = pwdata_in[CC_SYNC_BIT];
      s_next.capsel[ch] = pwdata_in[CC_CAPSEL_BIT];
      s_next.om[ch] = pwdata_in[CC_OM_LSB +: 3];
      s_next.ie[ch] = pwdata_in[CC_IE_BIT];
      s_next.outval[ch] = pwdata_in[CC_OUTVAL_BIT];
      s_next.ovr[ch] = pwdata_in[CC_OVR_BIT];
      s_next.flag[ch] = pwdata_in[CC_FLAG_BIT];
    end
    // no shadow: dead time is software's concern
    if (wr && in_ccr) begin
      s_next.ccr[ch] = pwdata_in[15:0];
    end
    // counter
    if (clr) begin
      s_next.cnt = RESET_VALUE;
      s_next.down = 1'b0;
    end else if (cnt_wr) begin
      s_next.cnt = pwdata_in[15:0];
    end else if (run) begin
      s_next.cnt = nxt;
      s_next.down = nd;
    end
    // hardware sets last so a set beats a same-cycle clear
    if (run && wrap) begin
      s_next.ovf = 1'b1;
    end
    for (int i = 0; i < NCH; i++) begin
      // the value kept is the count before this edge's step
      if (capt_edge[i]) begin
        s_next.ccr[i] = s_reg.cnt;
        s_next.flag[i] = 1'b1;
        if (s_reg.unread[i]) begin
          s_next.ovr[i] = 1'b1;
        end
        s_next.unread[i] = 1'b1;
      end
      if (eqn[i]) begin
        s_next.flag[i] = 1'b1;
        s_next.latched[i] = lvl[i];
      end
      // output unit, clocked in every mode but mode 0
      case (s_reg.om[i])
        OM_SET: begin
          if (eqn[i]) begin
            s_next.out[i] = 1'b1;
          end
        end
        // channel event has priority over the period event
        OM_TGL_RST: begin
          if (eqn[i]) begin
            s_next.out[i] = ~s_reg.out[i];
          end else if (eq0) begin
            s_next.out[i] = 1'b0;
          end
        end
        OM_SET_RST: begin
          if (eqn[i]) begin
            s_next.out[i] = 1'b1;
          end else if (eq0) begin
            s_next.out[i] = 1'b0;
          end
        end
        OM_TGL: begin
          if (eqn[i]) begin
            s_next.out[i] = ~s_reg.out[i];
          end
        end
        OM_RST: begin
          if (eqn[i]) begin
            s_next.out[i] = 1'b0;
          end
        end
        OM_TGL_SET: begin
          if (eqn[i]) begin
            s_next.out[i] = ~s_reg.out[i];
          end else if (eq0) begin
            s_next.out[i] = 1'b1;
          end
        end
        OM_RST_SET: begin
          if (eqn[i]) begin
            s_next.out[i] = 1'b0;
          end else if (eq0) begin
            s_next.out[i] = 1'b1;
          end
        end
        default: s_next.out[i] = s_reg.outval[i];
      endcase
      // a timer clear also ends a latched set
      if (clr && s_reg.om[i] == OM_SET) begin
        s_next.out[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // mode 0 bypasses the flop, so it moves at the write edge
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (s_reg.om[i] == OM_OUT) begin
        unit_output_out[i] = s_reg.outval[i];
      end else begin
        unit_output_out[i] = s_reg.out[i];
      end
    end
  end

  // request lines; mode-bit hazards are left to software
  assign irq_channel0_out = s_reg.flag[0] & s_reg.ie[0] & s_reg.global_irq_enable;
  assign irq_shared_out = (iv != RESET_VALUE) & s_reg.global_irq_enable;
endmodule
